// >>> logic/cfm_pkg.sv
/*
 * Shared constants and types for the clock fail monitor: register map,
 * field positions, reset values, oscillator mode codes, state and carrier types.
 * Assumes a single aclk domain and 32-bit AXI4-Lite register access.
 */
package cfm_pkg;

    // register byte offsets
    localparam int          CFM_AW          = 8;
    localparam logic [7:0]  CFM_OFF_CTL     = 8'h00;
    localparam logic [7:0]  CFM_OFF_STAT    = 8'h04;
    localparam logic [7:0]  CFM_OFF_IE2     = 8'h08;
    localparam logic [7:0]  CFM_OFF_IF2     = 8'h0C;

    // control register fields and reset values
    localparam int          CFM_IRCF_LSB    = 3;
    localparam int          CFM_SCS_LSB     = 0;
    localparam logic [3:0]  CFM_IRCF_RST    = 4'h7;
    localparam logic [1:0]  CFM_SCS_RST     = 2'h0;
    localparam logic [1:0]  CFM_SCS_SEC     = 2'h1;

    // status register bit positions
    localparam int          CFM_ST_SECONDARY_OSC_READY    = 7;
    localparam int          CFM_ST_STARTUP_TIMER_DONE     = 5;
    localparam int          CFM_ST_HFR      = 4;
    localparam int          CFM_ST_LFR      = 1;
    localparam int          CFM_ST_HFS      = 0;

    // fail flag and its enable share one bit position
    localparam int          CFM_OSF_BIT     = 7;

    // counts: start-up timer pulses and monitor window in time-base cycles
    localparam int          CFM_OST_COUNT   = 1024;
    localparam int          CFM_FAIL_WINDOW = 32;

    // AXI responses
    localparam logic [1:0]  CFM_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  CFM_RESP_SLVERR = 2'h2;

    // configuration-word oscillator mode codes
    localparam logic [2:0]  CFM_FOSC_LP     = 3'h0;
    localparam logic [2:0]  CFM_FOSC_XT     = 3'h1;
    localparam logic [2:0]  CFM_FOSC_HS     = 3'h2;
    localparam logic [2:0]  CFM_FOSC_EXT_RESISTOR_CAP  = 3'h3;
    localparam logic [2:0]  CFM_FOSC_INTERNAL_OSC_BLOCK = 3'h4;
    localparam logic [2:0]  CFM_FOSC_ECL    = 3'h5;
    localparam logic [2:0]  CFM_FOSC_ECM    = 3'h6;
    localparam logic [2:0]  CFM_FOSC_ECH    = 3'h7;

    typedef enum logic [2:0] {
        CFM_ST_BOOT,
        CFM_ST_STARTUP,
        CFM_ST_EXT,
        CFM_ST_SEC,
        CFM_ST_INT,
        CFM_ST_FAILSAFE,
        CFM_ST_SLEEP
    } cfm_state_t;

    typedef enum logic [1:0] {
        CFM_SRC_INT,
        CFM_SRC_PRIM,
        CFM_SRC_SEC
    } cfm_src_t;

    // configuration-word straps
    typedef struct packed {
        logic [2:0] fosc;
        logic       fail_monitor_enable;
        logic       two_speed_enable;
    } cfm_cfg_t;

    // sampled oscillator levels and ready indications
    typedef struct packed {
        logic prim_clk;
        logic sec_clk;
        logic lf_clk;
        logic secondary_osc_ready;
        logic hf_int_ready;
        logic lf_int_ready;
        logic hf_int_stable;
    } cfm_osc_in_t;

endpackage

// >>> logic/cfm_clock_fail_monitor.sv
/*
 * Clock fail monitor and system clock source selection with an AXI4-Lite
 * register slave (control, status, interrupt enable, interrupt flag).
 * Assumes oscillator levels, straps and sleep/wake strobes are synchronous
 * to aclk, and that aclk runs far faster than any monitored oscillator.
 */
// How it works
// RULE1: falling edges of monitored clock timed by slow oscillator; failure in 32-96 ticks; this code detects in 32-64 ticks
// RULE2: on failure run from internal oscillator at chosen frequency; set fail flag
// RULE3: interrupt request only while fail flag and its enable are both set
// RULE4: after failure stay on internal source until fail-safe state clears
// RULE5: fail-safe state clears on reset, sleep, or clock select change
// RULE6: select change restarts start-up timer; clears only after switch to external
// RULE7: a failure still present after recovery sets the fail flag again
// RULE8: software should clear the fail flag before switching back
// RULE9: crystal recovery: select internal, clear flag, write 00, timer then switch
// RULE10: external clock mode: writing 00 switches at once without start-up timer
// RULE11: secondary recovery: wait for ready, write 01; switch at once, clear
// RULE12: select 1x internal, 01 secondary, 00 configured oscillator mode
// RULE13: crystal modes monitor only after start-up timer expires; runs after reset/wake
// RULE14: external clock modes skip start-up timer; monitor right after reset/wake
// RULE15: monitor inactive during oscillator start-up after reset or sleep
// RULE16: monitor enable also enables two-speed start-up on internal oscillator
// RULE17: monitor enabled by config bit; covers crystal, external, RC, secondary
// RULE18: four-bit frequency select picks internal oscillator frequency, 1111 fastest
// RULE19: start-up done bit set once 1024 clocks counted and crystal running
// RULE20: start-up timer runs after wake from sleep and after every reset
// RULE21: secondary oscillator runs only while its enable bit is set
// RULE22: failure when no edge within a time-base window, then rearm
`timescale 1ns/100ps
module cfm_clock_fail_monitor #(
    parameter int OST_COUNT   = cfm_pkg::CFM_OST_COUNT,
    parameter int FAIL_WINDOW = cfm_pkg::CFM_FAIL_WINDOW
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [cfm_pkg::CFM_AW-1:0]    s_axi_awaddr,
    input  wire logic [2:0]                    s_axi_awprot,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    output logic [1:0]                         s_axi_bresp,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    input  wire logic [cfm_pkg::CFM_AW-1:0]    s_axi_araddr,
    input  wire logic [2:0]                    s_axi_arprot,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    input  wire cfm_pkg::cfm_cfg_t             cfg,
    input  wire cfm_pkg::cfm_osc_in_t          osc_in,
    input  wire logic                          sleep_req,
    input  wire logic                          wake_req,
    input  wire logic                          secondary_osc_enable,
    output cfm_pkg::cfm_src_t                  cpu_clk_src,
    output logic                               cpu_hold,
    output logic [3:0]                         int_osc_freq_select,
    output logic                               fail_safe_active,
    output logic                               osc_fail_irq,
    output logic                               secondary_osc_run,
    output logic                               startup_timer_done
);

    localparam int OW = $clog2(OST_COUNT + 1);
    localparam int WW = $clog2(FAIL_WINDOW);

    cfm_pkg::cfm_state_t state_r;
    cfm_pkg::cfm_state_t sel_state;
    cfm_pkg::cfm_src_t   src_nxt;
    logic [3:0]          int_freq_r;
    logic [1:0]          sys_clk_select_r;
    logic                osc_fail_flag_r;
    logic                osc_fail_irq_enable_r;
    logic                failsafe_r;
    logic [OW-1:0]       ost_cnt_r;
    logic [WW-1:0]       wnd_cnt_r;
    logic                edge_seen_r;
    logic                prim_q_r;
    logic                sec_q_r;
    logic                lf_q_r;
    logic                prim_fall;
    logic                mon_fall;
    logic                lf_fall;
    logic                mon_active;
    logic                fail_det;
    logic                ost_done;
    logic                aw_held_r;
    logic                w_held_r;
    logic [7:0]          aw_addr_r;
    logic [7:0]          w_byte_r;
    logic                w_lane_r;
    logic                wr_go;
    logic                wr_hit;
    logic                scs_chg;
    logic [1:0]          scs_new;
    logic [7:0]          ctl_val;
    logic [7:0]          stat_val;
    logic [7:0]          rd_val;
    logic                rd_hit;

    // source chosen by a clock select value and the configured mode
    function automatic cfm_pkg::cfm_state_t pick_state(input logic [1:0] scs,
                                                       input logic [2:0] fosc);
        cfm_pkg::cfm_state_t st;
        st = cfm_pkg::CFM_ST_EXT;
        if (scs[1]) begin
            st = cfm_pkg::CFM_ST_INT;                              // RULE12
        end else if (scs == cfm_pkg::CFM_SCS_SEC) begin
            st = cfm_pkg::CFM_ST_SEC;                              // RULE11
        end else if (fosc == cfm_pkg::CFM_FOSC_LP || fosc == cfm_pkg::CFM_FOSC_XT ||
                     fosc == cfm_pkg::CFM_FOSC_HS) begin
            st = cfm_pkg::CFM_ST_STARTUP;                          // RULE9
        end else if (fosc == cfm_pkg::CFM_FOSC_INTERNAL_OSC_BLOCK) begin
            st = cfm_pkg::CFM_ST_INT;
        end
        return st;                                                 // RULE10
    endfunction

    // edge detection on the sampled oscillator levels
    assign prim_fall = prim_q_r & ~osc_in.prim_clk;
    assign lf_fall   = lf_q_r & ~osc_in.lf_clk;
    assign mon_fall  = (state_r == cfm_pkg::CFM_ST_SEC) ? (sec_q_r & ~osc_in.sec_clk)
                                                         : prim_fall;
    assign ost_done  = (ost_cnt_r == OW'(OST_COUNT));

    // only a running external or secondary source is watched
    assign mon_active = cfg.fail_monitor_enable &&                 // RULE17
                        (state_r == cfm_pkg::CFM_ST_EXT ||
                         state_r == cfm_pkg::CFM_ST_SEC);          // RULE15

    // a whole window of time-base ticks with no edge is a failure
    assign fail_det = mon_active && lf_fall && !edge_seen_r && !mon_fall &&
                      (wnd_cnt_r == WW'(FAIL_WINDOW - 1));         // RULE22

    // write decode: both address and data held
    assign wr_go   = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_hit  = (aw_addr_r == cfm_pkg::CFM_OFF_CTL) || (aw_addr_r == cfm_pkg::CFM_OFF_STAT) ||
                     (aw_addr_r == cfm_pkg::CFM_OFF_IE2) || (aw_addr_r == cfm_pkg::CFM_OFF_IF2);
    assign scs_new = w_byte_r[cfm_pkg::CFM_SCS_LSB +: 2];
    assign scs_chg = wr_go && w_lane_r && (aw_addr_r == cfm_pkg::CFM_OFF_CTL) &&
                     (scs_new != sys_clk_select_r);                // RULE6
    assign sel_state = pick_state(scs_chg ? scs_new : sys_clk_select_r, cfg.fosc);

    // register images
    always_comb begin
        ctl_val = 8'h00;
        ctl_val[cfm_pkg::CFM_IRCF_LSB +: 4] = int_freq_r;
        ctl_val[cfm_pkg::CFM_SCS_LSB +: 2]  = sys_clk_select_r;
        stat_val = 8'h00;
        stat_val[cfm_pkg::CFM_ST_SECONDARY_OSC_READY] = secondary_osc_enable ? osc_in.secondary_osc_ready
                                                               : 1'b1;
        stat_val[cfm_pkg::CFM_ST_STARTUP_TIMER_DONE]  = (state_r == cfm_pkg::CFM_ST_EXT); // RULE19
        stat_val[cfm_pkg::CFM_ST_HFR]   = osc_in.hf_int_ready;
        stat_val[cfm_pkg::CFM_ST_LFR]   = osc_in.lf_int_ready;
        stat_val[cfm_pkg::CFM_ST_HFS]   = osc_in.hf_int_stable;
    end

    // read decode
    always_comb begin
        rd_val = 8'h00;
        rd_hit = 1'b1;
        if (s_axi_araddr == cfm_pkg::CFM_OFF_CTL) begin
            rd_val = ctl_val;
        end else if (s_axi_araddr == cfm_pkg::CFM_OFF_STAT) begin
            rd_val = stat_val;
        end else if (s_axi_araddr == cfm_pkg::CFM_OFF_IE2) begin
            rd_val[cfm_pkg::CFM_OSF_BIT] = osc_fail_irq_enable_r;
        end else if (s_axi_araddr == cfm_pkg::CFM_OFF_IF2) begin
            rd_val[cfm_pkg::CFM_OSF_BIT] = osc_fail_flag_r;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_byte_r      <= 8'h00;
            w_lane_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= cfm_pkg::CFM_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !wr_go;
            s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !wr_go;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_byte_r <= s_axi_wdata[7:0];
                w_lane_r <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? cfm_pkg::CFM_RESP_OKAY : cfm_pkg::CFM_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= cfm_pkg::CFM_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rd_val};
                s_axi_rresp  <= rd_hit ? cfm_pkg::CFM_RESP_OKAY : cfm_pkg::CFM_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // control register; status is live and read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_freq_r       <= cfm_pkg::CFM_IRCF_RST;
            sys_clk_select_r <= cfm_pkg::CFM_SCS_RST;
        end else if (wr_go && w_lane_r && aw_addr_r == cfm_pkg::CFM_OFF_CTL) begin
            int_freq_r       <= w_byte_r[cfm_pkg::CFM_IRCF_LSB +: 4];    // RULE18
            sys_clk_select_r <= scs_new;
        end
    end

    // interrupt enable and fail flag; a hardware set beats a software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_fail_irq_enable_r <= 1'b0;
            osc_fail_flag_r       <= 1'b0;
        end else begin
            if (wr_go && w_lane_r && aw_addr_r == cfm_pkg::CFM_OFF_IE2) begin
                osc_fail_irq_enable_r <= w_byte_r[cfm_pkg::CFM_OSF_BIT];
            end
            if (fail_det) begin
                osc_fail_flag_r <= 1'b1;                           // RULE7
            end else if (wr_go && w_lane_r && aw_addr_r == cfm_pkg::CFM_OFF_IF2) begin
                osc_fail_flag_r <= w_byte_r[cfm_pkg::CFM_OSF_BIT]; // RULE8
            end
        end
    end

    // previous samples for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prim_q_r <= 1'b0;
            sec_q_r  <= 1'b0;
            lf_q_r   <= 1'b0;
        end else begin
            prim_q_r <= osc_in.prim_clk;
            sec_q_r  <= osc_in.sec_clk;
            lf_q_r   <= osc_in.lf_clk;
        end
    end

    // monitor window: latency lies between one and two windows
    always_ff @(posedge aclk) begin
        if (!aresetn || !mon_active) begin
            wnd_cnt_r   <= '0;
            edge_seen_r <= 1'b0;
        end else if (lf_fall) begin
            wnd_cnt_r <= (wnd_cnt_r == WW'(FAIL_WINDOW - 1)) ? '0 : wnd_cnt_r + 1'b1; // RULE1
            if (wnd_cnt_r == WW'(FAIL_WINDOW - 1)) begin
                edge_seen_r <= 1'b0;                               // RULE22
            end else if (mon_fall) begin
                edge_seen_r <= 1'b1;
            end
        end else if (mon_fall) begin
            edge_seen_r <= 1'b1;
        end
    end

    // start-up timer counts primary falling edges, restarted on every entry
    always_ff @(posedge aclk) begin
        if (!aresetn || state_r != cfm_pkg::CFM_ST_STARTUP || scs_chg || sleep_req) begin
            ost_cnt_r <= '0;                                       // RULE20
        end else if (prim_fall && !ost_done) begin
            ost_cnt_r <= ost_cnt_r + 1'b1;
        end
    end

    // source sequencing; sleep first, then a select change, then events
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= cfm_pkg::CFM_ST_BOOT;
        end else if (sleep_req && state_r != cfm_pkg::CFM_ST_SLEEP) begin
            state_r <= cfm_pkg::CFM_ST_SLEEP;                      // RULE5
        end else if (scs_chg && state_r != cfm_pkg::CFM_ST_SLEEP) begin
            state_r <= sel_state;                                  // RULE6
        end else begin
            case (state_r)
                cfm_pkg::CFM_ST_BOOT: begin
                    state_r <= sel_state;                          // RULE13
                end
                cfm_pkg::CFM_ST_STARTUP: begin
                    if (ost_done) begin
                        state_r <= cfm_pkg::CFM_ST_EXT;
                    end
                end
                cfm_pkg::CFM_ST_EXT, cfm_pkg::CFM_ST_SEC: begin
                    if (fail_det) begin
                        state_r <= cfm_pkg::CFM_ST_FAILSAFE;       // RULE2
                    end
                end
                cfm_pkg::CFM_ST_SLEEP: begin
                    if (wake_req) begin
                        state_r <= sel_state;                      // RULE14
                    end
                end
                default: begin
                    state_r <= state_r;                            // RULE4
                end
            endcase
        end
    end

    // fail-safe condition; drops on sleep or once an external source really runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            failsafe_r <= 1'b0;
        end else if (fail_det) begin
            failsafe_r <= 1'b1;
        end else if (sleep_req || state_r == cfm_pkg::CFM_ST_EXT ||
                     state_r == cfm_pkg::CFM_ST_SEC) begin
            failsafe_r <= 1'b0;                                    // RULE5
        end
    end

    // clock source follows the state; anything else runs internal
    always_comb begin
        src_nxt = cfm_pkg::CFM_SRC_INT;
        if (state_r == cfm_pkg::CFM_ST_EXT) begin
            src_nxt = cfm_pkg::CFM_SRC_PRIM;
        end else if (state_r == cfm_pkg::CFM_ST_SEC) begin
            src_nxt = cfm_pkg::CFM_SRC_SEC;
        end
    end

    // registered outputs; one cycle behind the state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_clk_src         <= cfm_pkg::CFM_SRC_INT;
            cpu_hold            <= 1'b1;
            int_osc_freq_select <= cfm_pkg::CFM_IRCF_RST;
            fail_safe_active    <= 1'b0;
            osc_fail_irq        <= 1'b0;
            secondary_osc_run   <= 1'b0;
            startup_timer_done  <= 1'b0;
        end else begin
            cpu_clk_src         <= src_nxt;                        // RULE2
            // without two-speed the core waits for the crystal in reset
            cpu_hold            <= (state_r == cfm_pkg::CFM_ST_BOOT) ||
                                   (state_r == cfm_pkg::CFM_ST_STARTUP &&
                                    !cfg.fail_monitor_enable &&
                                    !cfg.two_speed_enable);        // RULE16
            int_osc_freq_select <= int_freq_r;                     // RULE18
            fail_safe_active    <= failsafe_r && (src_nxt == cfm_pkg::CFM_SRC_INT); // RULE4
            osc_fail_irq        <= osc_fail_flag_r && osc_fail_irq_enable_r; // RULE3
            secondary_osc_run   <= secondary_osc_enable;          // RULE21
            startup_timer_done  <= (state_r == cfm_pkg::CFM_ST_EXT); // RULE19
        end
    end

endmodule

// >>> test/cfm_props.sv
/* checker for the clock fail monitor, bound onto its top ports.
   assumes one aclk domain and a synchronous active-low reset. */
`timescale 1ns/100ps
module cfm_props #(parameter int FAIL_WINDOW = 32) (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire cfm_pkg::cfm_cfg_t    cfg,
    input wire cfm_pkg::cfm_osc_in_t osc_in,
    input wire logic                 sleep_req,
    input wire cfm_pkg::cfm_src_t    cpu_clk_src,
    input wire logic                 cpu_hold,
    input wire logic [3:0]           int_osc_freq_select,
    input wire logic                 fail_safe_active,
    input wire logic                 startup_timer_done
);
    logic       pp_r, lp_r;
    logic [7:0] gap_r;
    // time-base ticks since the last crystal falling edge, saturating
    always_ff @(posedge aclk) begin
        pp_r <= osc_in.prim_clk;
        lp_r <= osc_in.lf_clk;
        if (!aresetn || (pp_r && !osc_in.prim_clk)) gap_r <= 8'h00;
        else if (lp_r && !osc_in.lf_clk && gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_to_int;
        $past(cpu_clk_src) != cfm_pkg::CFM_SRC_INT ##0 cpu_clk_src == cfm_pkg::CFM_SRC_INT;
    endsequence
    a_fail_to_int: assert property ($rose(fail_safe_active) |-> s_to_int)
        else $error("fail-safe entry without move to internal source");
    a_fail_late: assert property (cfg.fail_monitor_enable && cpu_clk_src == cfm_pkg::CFM_SRC_PRIM
        |-> gap_r <= 2 * FAIL_WINDOW + 2) else $error("stopped clock not caught in time");
    a_fail_early: assert property ($rose(fail_safe_active) |-> gap_r >= FAIL_WINDOW - 1)
        else $error("failure declared too soon");
    a_hold_release: assert property (cpu_hold && cfg.fail_monitor_enable |-> ##[1:3] !cpu_hold)
        else $error("core held although monitor enabled");
    a_done_on_prim: assert property (startup_timer_done |-> cpu_clk_src == cfm_pkg::CFM_SRC_PRIM)
        else $error("start-up done while not on crystal");
    a_safe_on_int: assert property (fail_safe_active |-> cpu_clk_src == cfm_pkg::CFM_SRC_INT)
        else $error("fail-safe but not on internal source");
    a_reset_state: assert property ($rose(aresetn) |-> cpu_clk_src == cfm_pkg::CFM_SRC_INT
        && !fail_safe_active && int_osc_freq_select == cfm_pkg::CFM_IRCF_RST)
        else $error("wrong state after reset");
    a_sleep_clear: assert property (sleep_req |-> ##[1:3] !fail_safe_active && !startup_timer_done)
        else $error("sleep did not clear fail-safe");
    a_ost_on_int: assert property ($rose(startup_timer_done) |-> $past(cpu_clk_src) == cfm_pkg::CFM_SRC_INT)
        else $error("timer count not run from internal source");
endmodule
bind cfm_clock_fail_monitor cfm_props #(.FAIL_WINDOW(FAIL_WINDOW)) u_props (.*);

// >>> test/cfm_osc_model.sv
/* oscillator stand-in: stoppable crystal, free time base, secondary.
   assumes aclk is far faster than every clock made here. */
`timescale 1ns/100ps
module cfm_osc_model (
    input  wire logic aclk,
    input  wire logic run,
    output logic      prim_clk,
    output logic      sec_clk,
    output logic      lf_clk
);
    logic [4:0] ph_r = 5'h00;
    // a dead crystal rests low instead of toggling
    always @(posedge aclk) begin
        ph_r     <= ph_r + 5'h01;
        prim_clk <= run & ph_r[1];
    end
    assign sec_clk = ph_r[2];
    assign lf_clk  = ph_r[4];
endmodule

// >>> test/tb.sv
/* self-checking bench: crystal start, failure, recovery, refail, sleep.
   assumes the monitor and the oscillator stand-in are compiled first. */
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
`define WAIT_FOR(c) begin int k; for (k = 0; k < 4000 && !(c); k++) @(posedge aclk); end
module tb;
    int fails = 0, n_tests = 0;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, sleep_req = 0, wake_req = 0, run = 1;
    logic secondary_osc_enable = 0, p, s, l;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'hF, int_osc_freq_select;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_hold;
    logic fail_safe_active, osc_fail_irq, secondary_osc_run, startup_timer_done;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    cfm_pkg::cfm_src_t    cpu_clk_src;
    cfm_pkg::cfm_cfg_t    cfg = '{cfm_pkg::CFM_FOSC_XT, 1'b1, 1'b1};
    cfm_pkg::cfm_osc_in_t osc_in;
    // internal oscillators always report ready
    assign osc_in = {p, s, l, 4'hF};
    cfm_osc_model osc (.aclk(aclk), .run(run), .prim_clk(p), .sec_clk(s), .lf_clk(l));
    cfm_clock_fail_monitor #(.OST_COUNT(16), .FAIL_WINDOW(4)) dut (.*);
    initial forever #2.5 aclk = ~aclk;
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, r)
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, {24'h0, d})
        `CHK(s_axi_rresp, r)
    endtask
    task automatic t_boot();
        rd(8'h04, 8'h93, 2'h0);
        rd(8'h00, 8'h38, 2'h0);
        rd(8'h10, 8'h00, 2'h2);
        wr(8'h04, 8'hFF, 2'h0);
        secondary_osc_enable <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK(secondary_osc_run, 1'b1)
        `WAIT_FOR(startup_timer_done === 1'b1)
        `CHK(cpu_clk_src, cfm_pkg::CFM_SRC_PRIM)
        rd(8'h04, 8'hB3, 2'h0);
    endtask
    task automatic t_fail();
        wr(8'h08, 8'h80, 2'h0);
        run <= 1'b0;
        `WAIT_FOR(fail_safe_active === 1'b1)
        `CHK(cpu_clk_src, cfm_pkg::CFM_SRC_INT)
        repeat (2) @(posedge aclk);
        `CHK(osc_fail_irq, 1'b1)
        rd(8'h0C, 8'h80, 2'h0);
        wr(8'h08, 8'h00, 2'h0);
        @(posedge aclk);
        `CHK(osc_fail_irq, 1'b0)
    endtask
    task automatic t_recover();
        run <= 1'b1;
        wr(8'h00, 8'h7A, 2'h0);
        @(posedge aclk);
        `CHK(int_osc_freq_select, 4'hF)
        `CHK(cpu_clk_src, cfm_pkg::CFM_SRC_INT)
        wr(8'h0C, 8'h00, 2'h0);
        rd(8'h0C, 8'h00, 2'h0);
        wr(8'h00, 8'h78, 2'h0);
        `WAIT_FOR(startup_timer_done === 1'b1)
        @(posedge aclk);
        `CHK(fail_safe_active, 1'b0)
        `CHK(cpu_clk_src, cfm_pkg::CFM_SRC_PRIM)
    endtask
    task automatic t_sleep();
        run <= 1'b1;
        sleep_req <= 1'b1;
        @(posedge aclk);
        sleep_req <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK(fail_safe_active, 1'b0)
        wake_req <= 1'b1;
        @(posedge aclk);
        wake_req <= 1'b0;
        `WAIT_FOR(startup_timer_done === 1'b1)
        `CHK(startup_timer_done, 1'b1)
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence: second failure after recovery must set the flag again
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_boot();
        t_fail();
        t_recover();
        t_fail();
        t_sleep();
        report_and_stop();
    end
    // watchdog, far beyond the several hundred cycles the run needs
    initial begin
        #50000;
        fails++;
        report_and_stop();
    end
endmodule
